/* rtl/ulms_core.sv */
// line status, modem status and auxiliary control of the serial unit
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns

// Operation
// - status read clears error and break flags
// - fifo error bit reads zero without fifo
// - break after spacing for whole character
// - fifo errors reported when character reaches top
// - break loads one zero character, waits marking
// - spacing stop bit sets framing error
// - after framing error start sampled twice
// - failed parity check sets parity error
// - unread buffer overwritten sets overrun
// - fifo full overrun drops shift character
// - modem bits 7:4 show inverted inputs
// - modem change bits set, cleared on read
// - scratch byte, no effect on unit
// - path and owner select for infrared
// - two bit transceiver model field
// - mode and rate only for model 01
// - soft reset held until written zero
// - echo mask bit, reset zero
// - reserved bits read zero, written zero
// - all-empty needs holding and shift empty
// - break control forces transmit spacing unless soft reset held
module ulms_core
(
	// clock and reset
	input  logic        aclk,
	input  logic        aresetn,
	// register bus
	input  logic [31:0] s_axi_awaddr,
	input  logic        s_axi_awvalid,
	output logic        s_axi_awready,
	input  logic [31:0] s_axi_wdata,
	input  logic [3:0]  s_axi_wstrb,
	input  logic        s_axi_wvalid,
	output logic        s_axi_wready,
	output logic [1:0]  s_axi_bresp,
	output logic        s_axi_bvalid,
	input  logic        s_axi_bready,
	input  logic [31:0] s_axi_araddr,
	input  logic        s_axi_arvalid,
	output logic        s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0]  s_axi_rresp,
	output logic        s_axi_rvalid,
	input  logic        s_axi_rready,
	// transmitter and baud generator
	input  logic        bit_tick,
	input  logic        tx_serial,
	input  logic        tx_holding_empty,
	input  logic        tx_shift_empty,
	// serial pins
	input  logic        rs232_rxd,
	input  logic        ir_rxd,
	output logic        rs232_txd,
	output logic        ir_txd,
	// modem pins
	input  logic        carrier_detect_in_n,
	input  logic        ring_indicate_in_n,
	input  logic        set_ready_in_n,
	input  logic        clear_to_send_in_n,
	// control outputs
	output logic        serial_unit_reset,
	output logic        fast_ir_owns_module,
	output logic [1:0]  module_type_field,
	output logic        transceiver_mode_bit,
	output logic        ir_rate_bit,
	output logic        echo_mask_bit,
	output logic        rx_ready_flag
);

	ulms_pkg::ulms_st_t  r;
	ulms_pkg::ulms_st_t  n;
	ulms_pkg::ulms_ent_t ent;
	ulms_pkg::ulms_ent_t head;
	logic                ar_hs;
	logic                aw_hs;
	logic                w_hs;
	logic                rd_ls;
	logic                rd_ms;
	logic                pop;
	logic                path;
	logic                rxs;
	logic                tx_empty;
	logic                fen;
	logic                done;
	logic                push;
	logic                ovw;
	logic                oe_set;
	logic                present;
	logic                c_brk;
	logic                c_fe;
	logic                c_pe;
	logic                tb;
	logic                rok;
	logic [7:0]          rv;
	logic [2:0]          last;
	logic [3:0]          mdiff;
	logic [ulms_pkg::PW-1:0] rp1;

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign s_axi_awready = ~r.aw_got & ~r.bvalid;
	assign s_axi_wready = ~r.w_got & ~r.bvalid;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_bresp = r.bresp;
	assign s_axi_arready = ~r.rvalid;
	assign s_axi_rvalid = r.rvalid;
	assign s_axi_rresp = r.rresp;
	assign s_axi_rdata = {24'h000000, r.rdata};
	assign rs232_txd = r.rs_txd;
	assign ir_txd = r.ir_txd;
	assign serial_unit_reset = r.srst;
	assign fast_ir_owns_module = r.irsel[ulms_pkg::IRS_OWNER];
	assign module_type_field = r.irsel[ulms_pkg::IRS_TY_HI:ulms_pkg::IRS_TY_LO];
	assign transceiver_mode_bit = r.irsel[ulms_pkg::IRS_MODE]
		& (module_type_field == ulms_pkg::TYPE_FAST);
	assign ir_rate_bit = r.irsel[ulms_pkg::IRS_RATE]
		& (module_type_field == ulms_pkg::TYPE_FAST);
	assign echo_mask_bit = r.emask;
	assign rx_ready_flag = r.rx.cnt != '0;
	assign mdiff = r.m2 ^ r.m3;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		n = r;
		ar_hs = s_axi_arvalid & ~r.rvalid;
		aw_hs = s_axi_awvalid & s_axi_awready;
		w_hs = s_axi_wvalid & s_axi_wready;
		fen = r.cfg[ulms_pkg::CFG_FEN];
		path = r.irsel[ulms_pkg::IRS_PATH];
		tx_empty = tx_holding_empty & tx_shift_empty;
		n.x1 = {ir_rxd, rs232_rxd};
		n.x2 = r.x1;
		n.m1 = {carrier_detect_in_n, ring_indicate_in_n, set_ready_in_n, clear_to_send_in_n};
		n.m2 = r.m1;
		n.m3 = r.m2;
		rxs = path ? r.x2[1] : r.x2[0];
		if (r.emask && path && !tx_empty)
		begin
			rxs = 1'b1;
		end
		rd_ls = ar_hs && (s_axi_araddr == ulms_pkg::A_LS);
		rd_ms = ar_hs && (s_axi_araddr == ulms_pkg::A_MS);
		pop = ar_hs && (s_axi_araddr == ulms_pkg::A_RB) && (r.rx.cnt != '0);

		// read mux
		rok = 1'b1;
		rv = 8'h00;
		case (s_axi_araddr)
			ulms_pkg::A_RB:   rv = r.rx.mem[r.rx.rp].data;
			// fifo error only in fifo mode
			ulms_pkg::A_LS:   rv = {r.rx.ferr & fen, tx_empty, tx_holding_empty, r.rx.brk,
				r.rx.fe, r.rx.pe, r.rx.oe, r.rx.cnt != '0};
			ulms_pkg::A_MS:   rv = {~r.m2, r.mchg};
			ulms_pkg::A_SC:   rv = r.sc;
			ulms_pkg::A_IRS:  rv = r.irsel;
			ulms_pkg::A_RST:  rv = {7'h00, r.srst};
			ulms_pkg::A_ECHO_MASK_BIT: rv = {7'h00, r.emask};
			ulms_pkg::A_CFG:  rv = r.cfg;
			default:          rok = 1'b0;
		endcase
		if (r.rvalid && s_axi_rready)
		begin
			n.rvalid = 1'b0;
		end
		if (ar_hs)
		begin
			n.rvalid = 1'b1;
			n.rdata = rv;
			n.rresp = rok ? ulms_pkg::RESP_OKAY : ulms_pkg::RESP_SLVERR;
		end

		// write path
		if (r.bvalid && s_axi_bready)
		begin
			n.bvalid = 1'b0;
		end
		if (aw_hs)
		begin
			n.aw_got = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (w_hs)
		begin
			n.w_got = 1'b1;
			n.wdata = s_axi_wdata[7:0];
			n.wen = s_axi_wstrb[0];
		end
		if (r.aw_got && r.w_got)
		begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = ulms_pkg::RESP_OKAY;
			if (!(r.awaddr inside {ulms_pkg::A_RB, ulms_pkg::A_LS, ulms_pkg::A_MS,
				ulms_pkg::A_SC, ulms_pkg::A_IRS, ulms_pkg::A_RST, ulms_pkg::A_ECHO_MASK_BIT,
				ulms_pkg::A_CFG}))
			begin
				n.bresp = ulms_pkg::RESP_SLVERR;
			end
			if (r.wen)
			begin
				case (r.awaddr)
					ulms_pkg::A_SC:   n.sc = r.wdata;
					ulms_pkg::A_IRS:  n.irsel = r.wdata & ulms_pkg::IRS_MASK;
					ulms_pkg::A_RST:  n.srst = r.wdata[0];
					ulms_pkg::A_ECHO_MASK_BIT: n.emask = r.wdata[0];
					ulms_pkg::A_CFG:  n.cfg = r.wdata & ulms_pkg::CFG_MASK;
					default:          n.sc = r.sc;
				endcase
			end
		end

		n.mchg = (r.mchg & ~{4{rd_ms}}) | mdiff;

		// character checks at stop sample
		last = ulms_pkg::LAST_BASE + {1'b0, r.cfg[ulms_pkg::CFG_LEN_HI:ulms_pkg::CFG_LEN_LO]};
		c_brk = r.rx.zero & ~rxs;
		c_fe = ~rxs;
		c_pe = r.cfg[ulms_pkg::CFG_PEN]
			& (^r.rx.shr ^ r.rx.par ^ ~r.cfg[ulms_pkg::CFG_EVEN]);
		ent = '{brk: c_brk, fe: c_fe, pe: c_pe, data: r.rx.shr};
		done = 1'b0;

		// ------------------------------------------------------------
		// receive sampler
		// ------------------------------------------------------------
		case (r.rx.st)
			ulms_pkg::RX_IDLE:
			begin
				if (bit_tick && !rxs)
				begin
					if (r.rx.resync && !r.rx.seen)
					begin
						n.rx.seen = 1'b1;
					end
					else
					begin
						n.rx.st = ulms_pkg::RX_DATA;
						n.rx.resync = 1'b0;
						n.rx.seen = 1'b0;
						n.rx.bitn = '0;
						n.rx.shr = '0;
						n.rx.par = 1'b0;
						n.rx.zero = 1'b1;
					end
				end
				else if (bit_tick)
				begin
					n.rx.seen = 1'b0;
				end
			end
			ulms_pkg::RX_DATA:
			begin
				if (bit_tick)
				begin
					n.rx.shr[r.rx.bitn] = rxs;
					n.rx.zero = r.rx.zero & ~rxs;
					n.rx.bitn = r.rx.bitn + 3'h1;
					if (r.rx.bitn == last)
					begin
						n.rx.st = r.cfg[ulms_pkg::CFG_PEN] ? ulms_pkg::RX_PAR : ulms_pkg::RX_STOP;
					end
				end
			end
			ulms_pkg::RX_PAR:
			begin
				if (bit_tick)
				begin
					n.rx.par = rxs;
					n.rx.zero = r.rx.zero & ~rxs;
					n.rx.st = ulms_pkg::RX_STOP;
				end
			end
			ulms_pkg::RX_STOP:
			begin
				if (bit_tick)
				begin
					done = 1'b1;
					n.rx.seen = 1'b0;
					n.rx.st = c_brk ? ulms_pkg::RX_MARK : ulms_pkg::RX_IDLE;
					n.rx.resync = c_fe & ~c_brk;
				end
			end
			ulms_pkg::RX_MARK:
			begin
				if (bit_tick && rxs)
				begin
					n.rx.st = ulms_pkg::RX_IDLE;
				end
			end
			default: n.rx.st = ulms_pkg::RX_IDLE;
		endcase

		// ------------------------------------------------------------
		// receive fifo
		// ------------------------------------------------------------
		push = 1'b0;
		ovw = 1'b0;
		oe_set = 1'b0;
		if (done)
		begin
			if (fen)
			begin
				oe_set = (r.rx.cnt == ulms_pkg::FULL) && !pop;
				push = !oe_set;
			end
			else
			begin
				ovw = (r.rx.cnt != '0) && !pop;
				oe_set = ovw;
				push = !ovw;
			end
		end
		rp1 = r.rx.rp + 4'h1;
		if (push)
		begin
			// break stored as one zero character
			n.rx.mem[r.rx.wp] = ent;
			n.rx.wp = r.rx.wp + 4'h1;
		end
		if (ovw)
		begin
			n.rx.mem[r.rx.rp] = ent;
		end
		if (pop)
		begin
			n.rx.rp = rp1;
		end
		n.rx.cnt = r.rx.cnt + {{ulms_pkg::PW{1'b0}}, push} - {{ulms_pkg::PW{1'b0}}, pop};

		present = 1'b0;
		head = ent;
		if (ovw || (push && (r.rx.cnt == '0 || (pop && r.rx.cnt == 5'h01))))
		begin
			present = 1'b1;
		end
		else if (pop && r.rx.cnt > 5'h01)
		begin
			present = 1'b1;
			head = r.rx.mem[rp1];
		end

		n.rx.oe = (r.rx.oe & ~rd_ls) | oe_set;
		n.rx.brk = (r.rx.brk & ~rd_ls) | (present & head.brk);
		n.rx.fe = (r.rx.fe & ~rd_ls) | (present & head.fe);
		n.rx.pe = (r.rx.pe & ~rd_ls) | (present & head.pe);
		n.rx.ferr = (r.rx.ferr & ~rd_ls) | (push & fen & (ent.brk | ent.fe | ent.pe));

		tb = r.cfg[ulms_pkg::CFG_BRK] ? 1'b0 : tx_serial;
		n.rs_txd = 1'b1;
		n.ir_txd = 1'b1;
		if (r.srst)
		begin
			n.rx = ulms_pkg::ulms_rst().rx;
		end
		else if (path)
		begin
			n.ir_txd = tb;
		end
		else
		begin
			n.rs_txd = tb;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			r <= ulms_pkg::ulms_rst();
		end
		else
		begin
			r <= n;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_ls_clr;
		rd_ls && !done && !pop |=> !r.rx.brk && !r.rx.fe && !r.rx.pe && !r.rx.oe && !r.rx.ferr;
	endproperty
	a_ls_clr: assert property (p_ls_clr) else $error("status read did not clear");

	property p_ferr_nf;
		rd_ls && !fen |=> s_axi_rvalid && !s_axi_rdata[7];
	endproperty
	a_ferr_nf: assert property (p_ferr_nf) else $error("fifo error seen without fifo");

	property p_brk_mark;
		r.rx.st == ulms_pkg::RX_STOP && bit_tick && c_brk && !r.srst
			|=> r.rx.st == ulms_pkg::RX_MARK;
	endproperty
	a_brk_mark: assert property (p_brk_mark) else $error("break did not wait marking");

	property p_resync;
		done && c_fe && !c_brk && !r.srst |=> r.rx.resync;
	endproperty
	a_resync: assert property (p_resync) else $error("no resync after framing");

	property p_ovr_nf;
		done && !fen && r.rx.cnt != '0 && !pop && !r.srst
			|=> r.rx.oe && r.rx.cnt == $past(r.rx.cnt);
	endproperty
	a_ovr_nf: assert property (p_ovr_nf) else $error("holding overrun missed");

	property p_ovr_ff;
		done && fen && r.rx.cnt == ulms_pkg::FULL && !pop && !r.srst
			|=> r.rx.oe && r.rx.cnt == ulms_pkg::FULL;
	endproperty
	a_ovr_ff: assert property (p_ovr_ff) else $error("fifo overrun wrong");

	property p_msr_lvl;
		rd_ms |=> s_axi_rdata[7:4] == ~$past(r.m2);
	endproperty
	a_msr_lvl: assert property (p_msr_lvl) else $error("modem levels wrong");

	property p_msr_chg;
		mdiff != 4'h0 |=> (r.mchg & $past(mdiff)) == $past(mdiff);
	endproperty
	a_msr_chg: assert property (p_msr_chg) else $error("modem change lost");

	property p_model;
		transceiver_mode_bit || ir_rate_bit |-> module_type_field == ulms_pkg::TYPE_FAST;
	endproperty
	a_model: assert property (p_model) else $error("mode bits on wrong model");

	property p_srst;
		r.srst |=> r.rx.cnt == '0 && r.rx.st == ulms_pkg::RX_IDLE;
	endproperty
	a_srst: assert property (p_srst) else $error("soft reset not held");

	property p_brkctl;
		r.cfg[ulms_pkg::CFG_BRK] && !r.srst && !path |=> !rs232_txd;
	endproperty
	a_brkctl: assert property (p_brkctl) else $error("break not driven");

	property p_setwin;
		rd_ls && done && fen && c_fe && r.rx.cnt == '0 && !r.srst |=> r.rx.fe;
	endproperty
	a_setwin: assert property (p_setwin) else $error("set lost to clearing read");

	c_break: cover property (done && c_brk);
	c_overrun: cover property (oe_set && fen);
	c_mchg_rd: cover property (rd_ms && r.mchg != 4'h0);

endmodule

/* common/ulms_pkg.sv */
// shared constants and types for the line and modem status block
package ulms_pkg;

	// ------------------------------------------------------------
	// register indices and byte addresses
	// ------------------------------------------------------------
	localparam logic [31:0] IDX_RB   = 32'h0c000000;
	localparam logic [31:0] IDX_LS   = 32'h0c000005;
	localparam logic [31:0] IDX_MS   = 32'h0c000006;
	localparam logic [31:0] IDX_SC   = 32'h0c000007;
	localparam logic [31:0] IDX_IRS  = 32'h0c000008;
	localparam logic [31:0] IDX_RST  = 32'h0c000009;
	localparam logic [31:0] IDX_ECHO_MASK_BIT = 32'h0c00000a;
	localparam logic [31:0] IDX_CFG  = 32'h0c00000b;
	localparam logic [31:0] A_RB     = IDX_RB << 2;
	localparam logic [31:0] A_LS     = IDX_LS << 2;
	localparam logic [31:0] A_MS     = IDX_MS << 2;
	localparam logic [31:0] A_SC     = IDX_SC << 2;
	localparam logic [31:0] A_IRS    = IDX_IRS << 2;
	localparam logic [31:0] A_RST    = IDX_RST << 2;
	localparam logic [31:0] A_ECHO_MASK_BIT   = IDX_ECHO_MASK_BIT << 2;
	localparam logic [31:0] A_CFG    = IDX_CFG << 2;

	// ------------------------------------------------------------
	// fields
	// ------------------------------------------------------------
	localparam int          IRS_PATH  = 0;
	localparam int          IRS_OWNER = 1;
	localparam int          IRS_TY_LO = 2;
	localparam int          IRS_TY_HI = 3;
	localparam int          IRS_RATE  = 4;
	localparam int          IRS_MODE  = 5;
	localparam logic [7:0]  IRS_MASK  = 8'h3f;
	localparam logic [1:0]  TYPE_FAST = 2'h1;
	localparam int          CFG_LEN_LO = 0;
	localparam int          CFG_LEN_HI = 1;
	localparam int          CFG_PEN   = 2;
	localparam int          CFG_EVEN  = 3;
	localparam int          CFG_BRK   = 4;
	localparam int          CFG_FEN   = 5;
	localparam logic [7:0]  CFG_MASK  = 8'h3f;
	localparam logic [2:0]  LAST_BASE = 3'h4;
	localparam logic [1:0]  RESP_OKAY = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam int          PW        = 4;
	localparam int          DEPTH     = 16;
	localparam logic [PW:0] FULL      = 5'h10;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		RX_IDLE = 5'h01,
		RX_DATA = 5'h02,
		RX_PAR  = 5'h04,
		RX_STOP = 5'h08,
		RX_MARK = 5'h10
	} ulms_rx_st_t;

	typedef struct packed {
		logic       brk;
		logic       fe;
		logic       pe;
		logic [7:0] data;
	} ulms_ent_t;

	typedef struct packed {
		ulms_rx_st_t            st;
		logic [2:0]             bitn;
		logic [7:0]             shr;
		logic                   zero;
		logic                   par;
		logic                   resync;
		logic                   seen;
		ulms_ent_t [DEPTH-1:0]  mem;
		logic [PW-1:0]          wp;
		logic [PW-1:0]          rp;
		logic [PW:0]            cnt;
		logic                   oe;
		logic                   pe;
		logic                   fe;
		logic                   brk;
		logic                   ferr;
	} ulms_rx_t;

	typedef struct packed {
		ulms_rx_t    rx;
		logic [1:0]  x1;
		logic [1:0]  x2;
		logic [3:0]  m1;
		logic [3:0]  m2;
		logic [3:0]  m3;
		logic [3:0]  mchg;
		logic [7:0]  sc;
		logic [7:0]  irsel;
		logic [7:0]  cfg;
		logic        srst;
		logic        emask;
		logic        aw_got;
		logic        w_got;
		logic [31:0] awaddr;
		logic [7:0]  wdata;
		logic        wen;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [7:0]  rdata;
		logic        rs_txd;
		logic        ir_txd;
	} ulms_st_t;

	function automatic ulms_st_t ulms_rst();
		ulms_st_t s;
		s = '0;
		s.rx.st = RX_IDLE;
		s.x1 = '1;
		s.x2 = '1;
		s.m1 = '1;
		s.m2 = '1;
		s.m3 = '1;
		s.rs_txd = 1'b1;
		s.ir_txd = 1'b1;
		return s;
	endfunction

endpackage

/* test/ulms_line_model.sv */
// serial line and modem pin model for the status block bench
`timescale 1ns/1ns

module ulms_line_model
#(
	parameter int TICK = 4
)
(
	// clock
	input  logic aclk,
	// baud tick and receive lines
	output logic bit_tick,
	output logic rs232_rxd,
	output logic ir_rxd,
	// modem pins, active low
	output logic carrier_detect_in_n,
	output logic ring_indicate_in_n,
	output logic set_ready_in_n,
	output logic clear_to_send_in_n
);
	int         cnt;
	logic [3:0] modem_n;

	assign carrier_detect_in_n = modem_n[3];
	assign ring_indicate_in_n  = modem_n[2];
	assign set_ready_in_n      = modem_n[1];
	assign clear_to_send_in_n  = modem_n[0];

	initial
	begin
		cnt = 0;
		bit_tick = 1'b0;
		rs232_rxd = 1'b1;
		ir_rxd = 1'b1;
		modem_n = 4'hf;
	end

	// one tick every TICK cycles
	always @(posedge aclk)
	begin
		cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
		bit_tick <= (cnt == TICK - 1);
	end

	// new modem levels just after an edge
	task automatic set_modem(input logic [3:0] v);
		@(posedge aclk);
		modem_n <= v;
	endtask

	// frame lsb first, one bit per tick, then back to marking
	task automatic send(input logic [11:0] f, input int n, input logic ir);
		int i;
		for (i = 0; i < n; i++)
		begin
			@(posedge aclk iff bit_tick);
			if (ir)
				ir_rxd <= f[i];
			else
				rs232_rxd <= f[i];
		end
		@(posedge aclk iff bit_tick);
		rs232_rxd <= 1'b1;
		ir_rxd <= 1'b1;
	endtask
endmodule

/* test/testbench.sv */
// self-checking bench for the line and modem status block
`timescale 1ns/1ns

module testbench;
	localparam int TICK = 4;
	logic        aclk;
	logic        aresetn;
	logic [31:0] s_axi_awaddr;
	logic        s_axi_awvalid;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_wvalid;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready;
	logic [31:0] s_axi_araddr;
	logic        s_axi_arvalid;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready;
	logic        bit_tick;
	logic        tx_serial;
	logic        tx_holding_empty;
	logic        tx_shift_empty;
	logic        rs232_rxd;
	logic        ir_rxd;
	logic        rs232_txd;
	logic        ir_txd;
	logic        carrier_detect_in_n;
	logic        ring_indicate_in_n;
	logic        set_ready_in_n;
	logic        clear_to_send_in_n;
	logic        serial_unit_reset;
	logic        fast_ir_owns_module;
	logic [1:0]  module_type_field;
	logic        transceiver_mode_bit;
	logic        ir_rate_bit;
	logic        echo_mask_bit;
	logic        rx_ready_flag;
	logic [3:0]  mn;
	logic [31:0] ra [4] = '{ulms_pkg::A_SC, ulms_pkg::A_IRS, ulms_pkg::A_RST, ulms_pkg::A_ECHO_MASK_BIT};
	logic [7:0]  rm [4] = '{8'hff, 8'h3f, 8'h01, 8'h01};
	int          err_total;
	int          compares;
	int          cyc;
	int          i;

	ulms_core dut
	(
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bit_tick,
		.tx_serial, .tx_holding_empty, .tx_shift_empty, .rs232_rxd, .ir_rxd,
		.rs232_txd, .ir_txd, .carrier_detect_in_n, .ring_indicate_in_n,
		.set_ready_in_n, .clear_to_send_in_n, .serial_unit_reset,
		.fast_ir_owns_module, .module_type_field, .transceiver_mode_bit,
		.ir_rate_bit, .echo_mask_bit, .rx_ready_flag
	);

	ulms_line_model #(.TICK(TICK)) line
	(
		.aclk, .bit_tick, .rs232_rxd, .ir_rxd, .carrier_detect_in_n,
		.ring_indicate_in_n, .set_ready_in_n, .clear_to_send_in_n
	);

	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// hang guard
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			err_total++;
			results();
		end
	end

	// ----
	// bus tasks
	// ----
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			err_total++;
			$display("Error at %0t ns: got %h, expected %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [7:0] d,
		input logic [1:0] er = ulms_pkg::RESP_OKAY);
		logic ta;
		logic tw;
		ta = 1'b0;
		tw = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(ta && tw))
		begin
			@(posedge aclk);
			if (!ta && s_axi_awready)
			begin
				ta = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!tw && s_axi_wready)
			begin
				tw = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask

	task automatic rdc(input logic [31:0] a, input logic [7:0] e,
		input logic [1:0] er = ulms_pkg::RESP_OKAY);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
		end
		while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
		end
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, {24'h000000, e});
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask

	task automatic rx(input logic [7:0] d, input logic pe, input logic p,
		input logic st, input logic ir);
		if (pe)
			line.send({1'b1, st, p, d, 1'b0}, 11, ir);
		else
			line.send({2'b11, st, d, 1'b0}, 10, ir);
		repeat (TICK) @(posedge aclk);
	endtask

	task automatic results();
		$display("Checks made: %0d, mismatches: %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ----
	// test sequence
	// ----
	initial
	begin
		err_total = 0;
		compares = 0;
		cyc = 0;
		aresetn = 1'b0;
		s_axi_awaddr = 32'h0;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h1;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 32'h0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		tx_serial = 1'b1;
		tx_holding_empty = 1'b1;
		tx_shift_empty = 1'b1;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (i = 0; i < 4; i++)
			rdc(ra[i], 8'h00);
		rdc(ulms_pkg::A_LS, 8'h60);
		rdc(ulms_pkg::A_CFG + 32'h4, 8'h00, ulms_pkg::RESP_SLVERR);
		wr(ulms_pkg::A_CFG + 32'h4, 8'hff, ulms_pkg::RESP_SLVERR);
		wr(ulms_pkg::A_LS, 8'hff);
		rdc(ulms_pkg::A_LS, 8'h60);
		for (i = 0; i < 4; i++)
		begin
			wr(ra[i], 8'hff);
			rdc(ra[i], rm[i]);
			wr(ra[i], 8'h00);
		end
		s_axi_wstrb <= 4'h0;
		wr(ulms_pkg::A_SC, 8'h55);
		s_axi_wstrb <= 4'h1;
		rdc(ulms_pkg::A_SC, 8'h00);
		for (i = 0; i < 4; i++)
		begin
			wr(ulms_pkg::A_IRS, {4'h3, i[1:0], 2'b10});
			chk({30'h0, module_type_field}, i);
			chk({30'h0, transceiver_mode_bit, ir_rate_bit}, (i == 1) ? 3 : 0);
			chk({31'h0, fast_ir_owns_module}, 32'h1);
		end
		wr(ulms_pkg::A_IRS, 8'h00);
		rdc(ulms_pkg::A_MS, 8'h00);
		mn = 4'hf;
		for (i = 0; i < 4; i++)
		begin
			mn[i] = 1'b0;
			line.set_modem(mn);
			repeat (4) @(posedge aclk);
			rdc(ulms_pkg::A_MS, {~mn, 4'h1 << i});
			rdc(ulms_pkg::A_MS, {~mn, 4'h0});
		end
		line.set_modem(4'hf);
		repeat (4) @(posedge aclk);
		rdc(ulms_pkg::A_MS, 8'h0f);
		wr(ulms_pkg::A_CFG, 8'h03);
		rx(8'h5a, 1'b0, 1'b0, 1'b1, 1'b0);
		rdc(ulms_pkg::A_LS, 8'h61);
		chk({31'h0, rx_ready_flag}, 32'h1);
		rdc(ulms_pkg::A_RB, 8'h5a);
		rdc(ulms_pkg::A_LS, 8'h60);
		rx(8'h11, 1'b0, 1'b0, 1'b1, 1'b0);
		rx(8'h22, 1'b0, 1'b0, 1'b1, 1'b0);
		rdc(ulms_pkg::A_LS, 8'h63);
		rdc(ulms_pkg::A_LS, 8'h61);
		rdc(ulms_pkg::A_RB, 8'h22);
		wr(ulms_pkg::A_CFG, 8'h07);
		rx(8'h35, 1'b1, ^8'h35, 1'b1, 1'b0);
		rdc(ulms_pkg::A_LS, 8'h65);
		rdc(ulms_pkg::A_LS, 8'h61);
		rdc(ulms_pkg::A_RB, 8'h35);
		wr(ulms_pkg::A_CFG, 8'h0c);
		line.send({4'hf, 1'b1, 1'b1, 5'h15, 1'b0}, 8, 1'b0);
		repeat (TICK) @(posedge aclk);
		rdc(ulms_pkg::A_LS, 8'h61);
		rdc(ulms_pkg::A_RB, 8'h15);
		wr(ulms_pkg::A_CFG, 8'h03);
		rx(8'h6c, 1'b0, 1'b0, 1'b0, 1'b0);
		rdc(ulms_pkg::A_LS, 8'h69);
		rdc(ulms_pkg::A_LS, 8'h61);
		rdc(ulms_pkg::A_RB, 8'h6c);
		line.send({2'b11, 8'h47, 2'b00}, 11, 1'b0);
		repeat (TICK) @(posedge aclk);
		rdc(ulms_pkg::A_RB, 8'h47);
		line.send(12'h000, 12, 1'b0);
		repeat (TICK) @(posedge aclk);
		rdc(ulms_pkg::A_LS, 8'h79);
		rdc(ulms_pkg::A_RB, 8'h00);
		rx(8'h81, 1'b0, 1'b0, 1'b1, 1'b0);
		rdc(ulms_pkg::A_RB, 8'h81);
		wr(ulms_pkg::A_CFG, 8'h23);
		for (i = 0; i < 17; i++)
			rx(i[7:0], 1'b0, 1'b0, 1'b1, 1'b0);
		rdc(ulms_pkg::A_LS, 8'h63);
		for (i = 0; i < 16; i++)
			rdc(ulms_pkg::A_RB, i[7:0]);
		rdc(ulms_pkg::A_LS, 8'h60);
		rx(8'h11, 1'b0, 1'b0, 1'b1, 1'b0);
		rx(8'h22, 1'b0, 1'b0, 1'b0, 1'b0);
		rdc(ulms_pkg::A_LS, 8'he1);
		rdc(ulms_pkg::A_RB, 8'h11);
		rdc(ulms_pkg::A_LS, 8'h69);
		rdc(ulms_pkg::A_RB, 8'h22);
		line.send({2'b11, 8'h47, 2'b00}, 11, 1'b0);
		repeat (TICK) @(posedge aclk);
		rdc(ulms_pkg::A_RB, 8'h47);
		wr(ulms_pkg::A_CFG, 8'h13);
		@(negedge aclk);
		chk({30'h0, rs232_txd, ir_txd}, 32'h1);
		@(posedge aclk);
		tx_serial <= 1'b0;
		wr(ulms_pkg::A_CFG, 8'h03);
		wr(ulms_pkg::A_IRS, 8'h01);
		@(negedge aclk);
		chk({30'h0, rs232_txd, ir_txd}, 32'h2);
		@(posedge aclk);
		wr(ulms_pkg::A_RST, 8'h01);
		@(negedge aclk);
		chk({30'h0, serial_unit_reset, ir_txd}, 32'h3);
		@(posedge aclk);
		rx(8'h3c, 1'b0, 1'b0, 1'b1, 1'b1);
		rdc(ulms_pkg::A_LS, 8'h60);
		wr(ulms_pkg::A_RST, 8'h00);
		@(negedge aclk);
		chk({30'h0, serial_unit_reset, ir_txd}, 32'h0);
		@(posedge aclk);
		wr(ulms_pkg::A_ECHO_MASK_BIT, 8'h01);
		chk({31'h0, echo_mask_bit}, 32'h1);
		tx_shift_empty <= 1'b0;
		rx(8'h3c, 1'b0, 1'b0, 1'b1, 1'b1);
		rdc(ulms_pkg::A_LS, 8'h20);
		tx_holding_empty <= 1'b0;
		wr(ulms_pkg::A_ECHO_MASK_BIT, 8'h00);
		rx(8'h3c, 1'b0, 1'b0, 1'b1, 1'b1);
		rdc(ulms_pkg::A_LS, 8'h01);
		rdc(ulms_pkg::A_RB, 8'h3c);
		results();
	end
endmodule
